// [design/cpr_pkg.sv]
// Package: register map, field positions, reset values and carriers for
// the calibration and playback control register bank.
// Assumes a 16-bit register port fed by the serial-port decoder.
package cpr_pkg;

   // ***********************************************************
   // Register addresses
   // ***********************************************************
   localparam logic [5:0] ADDR_CAL_CFG  = 6'h0D;
   localparam logic [5:0] ADDR_CMP_OFS  = 6'h0E;
   localparam logic [5:0] ADDR_UPDATE   = 6'h1D;
   localparam logic [5:0] ADDR_PLAY_CMD = 6'h1E;
   localparam logic [5:0] ADDR_RPT_SEL  = 6'h1F;
   localparam logic [5:0] ADDR_DLY      = 6'h20;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int FLAG_LSB   = 9;    // Six result flags at 14:9
   localparam int FLAG_MSB   = 14;
   localparam int CAL_RST_B  = 8;
   localparam int CAL_USE_B  = 7;
   localparam int CAL_MEN_B  = 6;
   localparam int RNG_LSB    = 4;
   localparam int RNG_MSB    = 5;
   localparam int CLK_EN_B   = 3;
   localparam int DIV_LSB    = 0;
   localparam int DIV_MSB    = 2;
   localparam int OFS_LSB    = 8;    // Offset result at 14:8
   localparam int OFS_MSB    = 14;
   localparam int DONE_B     = 1;
   localparam int START_B    = 0;
   localparam int UPD_B      = 0;
   localparam int BUF_RD_B   = 3;
   localparam int MEM_ACC_B  = 2;
   localparam int PLAYING_B  = 1;
   localparam int RUN_B      = 0;
   localparam int RPT_B      = 0;

   // ***********************************************************
   // Reset values and timing
   // ***********************************************************
   localparam logic [2:0]  DIV_RST    = 3'h7;     // Divide by 512
   localparam logic [15:0] DLY_RST    = 16'h000E;
   localparam logic [2:0]  DIV_BASE   = 3'h2;     // Divide is 2^(2+N)
   localparam logic [8:0]  DIV_ONE    = 9'h001;
   localparam logic [7:0]  CAL_TICKS  = 8'h10;    // Cal clocks per cycle
   localparam logic [15:0] ZERO16     = 16'h0000;

   // ***********************************************************
   // Carriers
   // ***********************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [15:0] wdata;
   } cpr_req_t;

   typedef struct packed {
      logic [6:0] ofs;       // Comparator offset result
      logic [5:0] flags;     // Over/under flags, same order as 14:9
   } cpr_cal_res_t;

   typedef struct packed {
      logic        run;
      logic        rpt;
      logic [15:0] dly;
   } cpr_play_cfg_t;

endpackage

// [design/cpr_regs.sv]
// Calibration and playback control register bank of a quad DAC.
// Assumes a serial-port decoder that issues one-cycle register requests,
// calibration circuitry that supplies its measured results, and a
// playback engine that reports the end of each pattern period.
//
// Behaviour
// - Six read-only over/underflow flags at 14:9
// - Pulse of bit 8 clears calibration results
// - Bit 7 shows calibration results in use
// - Gain calibration enabled only by bit 6
// - Bit 3 gates the calibration clock
// - Calibration clock is clock over 2^(2+N)
// - Offset result readable at bits 14:8
// - Bit 1 flags calibration cycle finished
// - Bit 0 starts a calibration cycle
// - Update bit copies staged settings, self-clears
// - Buffer-read bit returns active, not staged
// - SRAM serial access only while bit 2
// - Bit 1 shows pattern being played
// - Run allows playback; cleared stops after trigger
// - Repeat mode: continuous or counted repeats
// - Playback starts delay plus two after trigger fall
`timescale 1ns/1ps

module cpr_regs (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  nrst,
   // Register port
   input  wire cpr_pkg::cpr_req_t     req,
   output logic [15:0]                rdata,
   output logic                       rvalid,
   // Calibration circuitry
   input  wire cpr_pkg::cpr_cal_res_t cal_meas,
   output logic                       cal_tick,
   output logic                       cal_busy,
   output logic                       gain_cal_en,
   output logic [1:0]                 cmp_ofs_range,
   // Playback engine
   input  wire logic                  trigger,
   input  wire logic                  pattern_end,
   input  wire logic [15:0]           repeat_count,
   output cpr_pkg::cpr_play_cfg_t     play_cfg,
   output logic                       play_start,
   output logic                       playing,
   output logic                       sram_access_en
);

   // ***********************************************************
   // State
   // ***********************************************************
   typedef enum logic [1:0] {C_IDLE, C_RUN, C_STORE} cpr_cal_st_t;
   typedef enum logic [1:0] {P_IDLE, P_DELAY, P_PLAY} cpr_play_st_t;

   typedef struct packed {
      logic [15:0]           rdata;
      logic                  rvalid;
      // Calibration configuration
      logic                  cal_rst;
      logic                  mode_en;
      logic [1:0]            rng;
      logic                  clk_en;
      logic [2:0]            div;
      logic                  start;
      // Calibration engine
      cpr_cal_st_t           cst;
      logic [8:0]            div_cnt;
      logic                  tick;
      logic [7:0]            tick_cnt;
      cpr_pkg::cpr_cal_res_t res;
      logic                  done;
      logic                  in_use;
      // Playback configuration
      logic                  upd;
      logic                  buf_rd;
      logic                  mem_acc;
      cpr_pkg::cpr_play_cfg_t stg;
      cpr_pkg::cpr_play_cfg_t act;
      // Playback engine
      cpr_play_st_t          pst;
      logic [15:0]           dly_cnt;
      logic [15:0]           rpt_cnt;
      logic                  trig_prev;
      logic                  start_p;
   } cpr_state_t;

   cpr_state_t s_q;
   cpr_state_t s_d;

   // Last count of the calibration clock divider for setting n
   function automatic logic [8:0] div_last(input logic [2:0] n);
      logic [3:0] sh;
      sh = {1'b0, n} + {1'b0, cpr_pkg::DIV_BASE};
      div_last = 9'((10'(1) << sh) - 10'(1));
   endfunction

   // Write strobe for one register address
   function automatic logic wr_hit(input cpr_pkg::cpr_req_t r,
                                   input logic [5:0] a);
      wr_hit = r.wr && (r.addr == a);
   endfunction

   logic trig_fall;

   // Trigger falling edge, trigger is synchronous to the clock;
   // a rising edge needs no action, playback arms only on the fall
   assign trig_fall = s_q.trig_prev && !trigger;

   // ***********************************************************
   // Next state
   // ***********************************************************
   // One pass computes every next value; later blocks override
   // earlier ones, so the calibration reset has the last word over
   // the sequencer, and the update copy runs before a new update
   // write, so a write in the copy cycle is not lost
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.tick = 1'b0;
      s_d.start_p = 1'b0;
      s_d.trig_prev = trigger;

      // Calibration configuration writes
      if (wr_hit(req, cpr_pkg::ADDR_CAL_CFG)) begin
         s_d.cal_rst = req.wdata[cpr_pkg::CAL_RST_B];
         s_d.mode_en = req.wdata[cpr_pkg::CAL_MEN_B];
         s_d.rng     = req.wdata[cpr_pkg::RNG_MSB:cpr_pkg::RNG_LSB];
         s_d.clk_en  = req.wdata[cpr_pkg::CLK_EN_B];
         s_d.div     = req.wdata[cpr_pkg::DIV_MSB:cpr_pkg::DIV_LSB];
      end

      // Calibration clock divider, runs only while enabled
      // Compare is >= so a smaller divider written mid-count
      // wraps at once instead of running on to the old limit
      // Clock gate
      if (!s_q.clk_en) begin
         s_d.div_cnt = '0;
      end else if (s_q.div_cnt >= div_last(s_q.div)) begin
         s_d.div_cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + cpr_pkg::DIV_ONE;
      end

      // Calibration cycle sequencer
      // Results are sampled on the last tick and the flag rises one
      // cycle later, so a poll that sees done also sees the results
      unique case (s_q.cst)
         C_IDLE: begin
            if (wr_hit(req, cpr_pkg::ADDR_CMP_OFS)
                && req.wdata[cpr_pkg::START_B] && !s_q.start) begin
               s_d.cst = C_RUN;
               s_d.done = 1'b0;
               s_d.tick_cnt = '0;
            end
         end
         C_RUN: begin
            if (s_q.tick) begin
               s_d.tick_cnt = s_q.tick_cnt + 8'h01;
               if (s_q.tick_cnt == cpr_pkg::CAL_TICKS - 8'h01) begin
                  s_d.res = cal_meas;
                  s_d.cst = C_STORE;
               end
            end
         end
         C_STORE: begin
            s_d.done = 1'b1;
            s_d.in_use = 1'b1;
            s_d.cst = C_IDLE;
         end
         default: s_d.cst = C_IDLE;
      endcase

      // Start bit is plain storage; the edge above launches a cycle
      // A start bit left at one blocks a new cycle until cleared
      if (wr_hit(req, cpr_pkg::ADDR_CMP_OFS)) begin
         s_d.start = req.wdata[cpr_pkg::START_B];
      end

      // The falling write of the reset bit clears results and flags
      // and aborts a running cycle; it also outranks a cycle that
      // completes in the same clock, so no stale flag survives
      // High then low clears
      if (s_q.cal_rst && wr_hit(req, cpr_pkg::ADDR_CAL_CFG)
          && !req.wdata[cpr_pkg::CAL_RST_B]) begin
         s_d.res = '0;
         s_d.done = 1'b0;
         s_d.in_use = 1'b0;
         s_d.cst = C_IDLE;
      end

      // Playback command and staged settings
      if (wr_hit(req, cpr_pkg::ADDR_PLAY_CMD)) begin
         s_d.buf_rd  = req.wdata[cpr_pkg::BUF_RD_B];
         s_d.mem_acc = req.wdata[cpr_pkg::MEM_ACC_B];
         s_d.stg.run = req.wdata[cpr_pkg::RUN_B];
      end
      if (wr_hit(req, cpr_pkg::ADDR_RPT_SEL)) begin
         s_d.stg.rpt = req.wdata[cpr_pkg::RPT_B];
      end
      if (wr_hit(req, cpr_pkg::ADDR_DLY)) begin
         s_d.stg.dly = req.wdata;
      end

      // The copy lands one clock after the write, so a read in
      // between still sees the update bit set
      // Copy then self-clear
      if (s_q.upd) begin
         s_d.act = s_q.stg;
         s_d.upd = 1'b0;
      end
      if (wr_hit(req, cpr_pkg::ADDR_UPDATE) && req.wdata[cpr_pkg::UPD_B]) begin
         s_d.upd = 1'b1;
      end

      // Trigger history resets high, so a trigger already low at
      // reset release reads as a fall; only run, reset to zero, keeps it from arming playback
      // With repeat mode on and a count of zero, playback ends at
      // the first pattern end, since the count is already reached
      // Playback sequencer
      unique case (s_q.pst)
         P_IDLE: begin
            if (s_q.act.run && trig_fall) begin
               s_d.pst = P_DELAY;
               s_d.dly_cnt = s_q.act.dly;
            end
         end
         P_DELAY: begin
            if (s_q.dly_cnt == cpr_pkg::ZERO16) begin
               s_d.pst = P_PLAY;
               s_d.start_p = 1'b1;
               s_d.rpt_cnt = '0;
            end else begin
               s_d.dly_cnt = s_q.dly_cnt - 16'h0001;
            end
         end
         P_PLAY: begin
            if (pattern_end && s_q.act.rpt) begin
               s_d.rpt_cnt = s_q.rpt_cnt + 16'h0001;
               if (s_q.rpt_cnt + 16'h0001 >= repeat_count) begin
                  s_d.pst = P_IDLE;
               end
            end
         end
         default: s_d.pst = P_IDLE;
      endcase

      if (s_q.pst != P_IDLE && !s_q.act.run && trig_fall) begin
         s_d.pst = P_IDLE;
      end

      // Reserved bits and unmapped addresses read as zero; a read
      // and a write in one cycle return the value before the write
      // Register read, answered one cycle later
      if (req.rd) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = '0;
         unique case (req.addr)
            cpr_pkg::ADDR_CAL_CFG: begin
               s_d.rdata[cpr_pkg::FLAG_MSB:cpr_pkg::FLAG_LSB] = s_q.res.flags;
               s_d.rdata[cpr_pkg::CAL_RST_B] = s_q.cal_rst;
               s_d.rdata[cpr_pkg::CAL_USE_B] = s_q.in_use;
               s_d.rdata[cpr_pkg::CAL_MEN_B] = s_q.mode_en;
               s_d.rdata[cpr_pkg::RNG_MSB:cpr_pkg::RNG_LSB] = s_q.rng;
               s_d.rdata[cpr_pkg::CLK_EN_B] = s_q.clk_en;
               s_d.rdata[cpr_pkg::DIV_MSB:cpr_pkg::DIV_LSB] = s_q.div;
            end
            cpr_pkg::ADDR_CMP_OFS: begin
               s_d.rdata[cpr_pkg::OFS_MSB:cpr_pkg::OFS_LSB] = s_q.res.ofs;
               s_d.rdata[cpr_pkg::DONE_B] = s_q.done;
               s_d.rdata[cpr_pkg::START_B] = s_q.start;
            end
            cpr_pkg::ADDR_UPDATE: begin
               s_d.rdata[cpr_pkg::UPD_B] = s_q.upd;
            end
            cpr_pkg::ADDR_PLAY_CMD: begin
               s_d.rdata[cpr_pkg::BUF_RD_B] = s_q.buf_rd;
               s_d.rdata[cpr_pkg::MEM_ACC_B] = s_q.mem_acc;
               s_d.rdata[cpr_pkg::PLAYING_B] = (s_q.pst == P_PLAY);
               s_d.rdata[cpr_pkg::RUN_B] =
                  s_q.buf_rd ? s_q.act.run : s_q.stg.run;
            end
            cpr_pkg::ADDR_RPT_SEL: begin
               s_d.rdata[cpr_pkg::RPT_B] =
                  s_q.buf_rd ? s_q.act.rpt : s_q.stg.rpt;
            end
            cpr_pkg::ADDR_DLY: begin
               s_d.rdata = s_q.buf_rd ? s_q.act.dly : s_q.stg.dly;
            end
            default: s_d.rdata = '0;  // Unmapped reads as zero
         endcase
      end
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   // Synchronous reset; the divider and delay come up at their
   // default settings rather than zero
   always_ff @(posedge clock) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.div <= cpr_pkg::DIV_RST;
         s_q.cst <= C_IDLE;
         s_q.pst <= P_IDLE;
         s_q.stg.dly <= cpr_pkg::DLY_RST;
         s_q.act.dly <= cpr_pkg::DLY_RST;
         s_q.trig_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   // Every output is a register or a decode of state, so no
   // request input reaches an output in the same cycle
   assign rdata = s_q.rdata;
   assign rvalid = s_q.rvalid;
   // Tick pulse is the gated calibration clock enable
   assign cal_tick = s_q.tick;
   assign cal_busy = (s_q.cst != C_IDLE);
   assign gain_cal_en = s_q.mode_en;
   assign cmp_ofs_range = s_q.rng;
   assign play_cfg = s_q.act;
   assign play_start = s_q.start_p;
   assign playing = (s_q.pst == P_PLAY);
   assign sram_access_en = s_q.mem_acc;

endmodule // cpr_regs

// [testbench/cpr_checker.sv]
// Checker: timing relations at the ports of the register bank.
// Assumes it is bound to cpr_regs and sees only that module's ports.
`timescale 1ns/1ps
module cpr_checker (
   // Clock and reset
   input wire logic                   clock,
   input wire logic                   nrst,
   // Register port
   input wire cpr_pkg::cpr_req_t      req,
   // Calibration side
   input wire logic                   cal_tick,
   input wire logic                   cal_busy,
   input wire logic                   gain_cal_en,
   // Playback side
   input wire logic                   trigger,
   input wire cpr_pkg::cpr_play_cfg_t play_cfg,
   input wire logic                   play_start,
   input wire logic                   playing,
   input wire logic                   sram_access_en
);
   logic        en_q, men_q, mem_q, seen_q, trg_q, wait_q;
   logic [2:0]  div_q;
   logic [9:0]  gap_q;
   logic [7:0]  tk_q;
   logic [16:0] cnt_q;
   wire         wr_cal = req.wr && req.addr == cpr_pkg::ADDR_CAL_CFG;

   // Shadow of written controls, tick spacing, arming and delay count
   always_ff @(posedge clock) begin
      if (!nrst) begin
         {en_q, men_q, mem_q, seen_q, wait_q} <= 5'h00;
         trg_q <= 1'b1;
         div_q <= 3'h7;
         gap_q <= 10'h000;
         tk_q  <= 8'h00;
         cnt_q <= 17'h00000;
      end else begin
         trg_q  <= trigger;
         gap_q  <= cal_tick ? 10'h001 : gap_q + 10'h001;
         seen_q <= wr_cal ? 1'b0 : (seen_q | cal_tick);
         tk_q   <= !cal_busy ? 8'h00 : tk_q + {7'h00, cal_tick};
         cnt_q  <= cnt_q + 17'h00001;
         if (wr_cal) begin
            en_q  <= req.wdata[3];
            men_q <= req.wdata[6];
            div_q <= req.wdata[2:0];
         end
         if (req.wr && req.addr == cpr_pkg::ADDR_PLAY_CMD) mem_q <= req.wdata[2];
         if (play_start) wait_q <= 1'b0;
         if (trg_q && !trigger) begin
            if (!play_cfg.run) wait_q <= 1'b0;
            else if (!wait_q && !playing) begin
               wait_q <= 1'b1;
               cnt_q  <= 17'h00001;
            end
         end
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   a_tick_gap: assert property (cal_tick && seen_q |-> gap_q == (10'h001 << ({1'b0, div_q} + 4'h2)))
      else $error("calibration tick spacing wrong");
   a_tick_gated: assert property (!en_q && !$past(en_q) |-> !cal_tick)
      else $error("calibration tick while clock disabled");
   a_gain_follow: assert property ($stable(men_q) |-> gain_cal_en == men_q)
      else $error("gain calibration enable differs from control");
   a_sram_follow: assert property ($stable(mem_q) |-> sram_access_en == mem_q)
      else $error("memory access enable differs from control");
   a_cal_ticks: assert property ($fell(cal_busy) && !$past(wr_cal) |-> tk_q == cpr_pkg::CAL_TICKS)
      else $error("calibration ended after wrong tick count");
   a_start_exact: assert property (play_start |-> wait_q && cnt_q == {1'b0, play_cfg.dly} + 17'h00002)
      else $error("playback start at wrong delay");
   a_start_late: assert property (wait_q |-> cnt_q <= {1'b0, play_cfg.dly} + 17'h00002)
      else $error("playback start overdue");
   a_start_pulse: assert property (play_start |-> playing ##1 !play_start)
      else $error("start pulse without playing or too long");
endmodule // cpr_checker

bind cpr_regs cpr_checker i_chk (
   .clock(clock), .nrst(nrst), .req(req), .cal_tick(cal_tick), .cal_busy(cal_busy),
   .gain_cal_en(gain_cal_en), .trigger(trigger), .play_cfg(play_cfg), .play_start(play_start),
   .playing(playing), .sram_access_en(sram_access_en));

// [testbench/cpr_host_model.sv]
// Host model: issues register writes and reads on the register port.
// Assumes the bank answers a read one cycle after the request edge.
`timescale 1ns/1ps
module cpr_host_model (
   // Clock
   input  wire logic         clock,
   // Register port
   output cpr_pkg::cpr_req_t req,
   input  wire logic [15:0]  rdata,
   input  wire logic         rvalid
);
   initial req = '{wr: 1'b0, rd: 1'b0, addr: 6'h00, wdata: 16'h0000};

   // One request for one cycle, then idle fields inverted
   task automatic put(input logic w, input logic [5:0] a, input logic [15:0] d);
      @(posedge clock) req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clock) req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      if (a == cpr_pkg::ADDR_CAL_CFG && d[2:0] < 3'h3) d[2:0] = 3'h3;
      put(1'b1, a, d);
   endtask

   task automatic rd(input logic [5:0] a, output logic [16:0] v);
      put(1'b0, a, 16'h0000);
      @(posedge clock) v = {rvalid, rdata};
   endtask

   task automatic cal_reset(input logic [15:0] cfg);
      wr(cpr_pkg::ADDR_CAL_CFG, cfg | 16'h0100);
      wr(cpr_pkg::ADDR_CAL_CFG, cfg);
   endtask
endmodule // cpr_host_model

// [testbench/cpr_regs_test.sv]
// Testbench: register table, update, playback and calibration cases.
// Assumes the host model drives the register port of the bank.
`timescale 1ns/1ps
module cpr_regs_test;
   typedef struct packed {logic [5:0] a; logic [15:0] d, e;} cpr_row_t;
   logic                   clock = 1'b0;
   logic                   nrst = 1'b0;
   logic                   trigger = 1'b1;
   logic                   pattern_end = 1'b0;
   logic [15:0]            repeat_count = 16'h0002;
   cpr_pkg::cpr_cal_res_t  cal_meas = '{ofs: 7'h5A, flags: 6'h2B};
   cpr_pkg::cpr_req_t      req;
   cpr_pkg::cpr_play_cfg_t play_cfg;
   logic [15:0]            rdata;
   logic [16:0]            v;
   logic [1:0]             rng;
   logic                   rvalid, cal_tick, cal_busy, gain_cal_en, play_start, playing, sram_access_en;
   int                     fails = 0, checked = 0, n;
   cpr_row_t               rows [9] = '{'{6'h0D, 16'hFFFF, 16'h017F}, '{6'h0D, 16'h0003, 16'h0003},
      '{6'h0E, 16'hFFFE, 16'h0000}, '{6'h1D, 16'h0000, 16'h0000}, '{6'h1E, 16'hFFF6, 16'h0004},
      '{6'h1E, 16'h0000, 16'h0000}, '{6'h1F, 16'hFFFF, 16'h0001}, '{6'h20, 16'hFFFF, 16'hFFFF},
      '{6'h3F, 16'hFFFF, 16'h0000}};

   // Clock of 100 ns
   always #50 clock = ~clock;

   cpr_regs i_dut (
      .clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid), .cal_meas(cal_meas),
      .cal_tick(cal_tick), .cal_busy(cal_busy), .gain_cal_en(gain_cal_en), .cmp_ofs_range(rng),
      .trigger(trigger), .pattern_end(pattern_end), .repeat_count(repeat_count), .play_cfg(play_cfg),
      .play_start(play_start), .playing(playing), .sram_access_en(sram_access_en));
   cpr_host_model i_host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));

   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
      i_host.rd(a, v);
      check("rdata", {1'b0, v}, {2'b01, exp});
   endtask
   task automatic rst;
      @(posedge clock) nrst <= 1'b0;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask
   task automatic fall;
      @(posedge clock) trigger <= 1'b1;
      @(posedge clock) trigger <= 1'b0;
   endtask
   task automatic fire(output int k);
      fall();
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (play_start !== 1'b1 && k < 300);
   endtask
   task automatic pend(input int k);
      repeat (k) begin
         @(posedge clock) pattern_end <= 1'b1;
         @(posedge clock) pattern_end <= 1'b0;
      end
   endtask
   task automatic complete_run;
      $display("Counts: %0d checked, %0d failed", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      cyc(20000);
      fails++;
      complete_run();
   end

   // Main sequence
   initial begin
      rst();
      foreach (rows[i]) begin
         i_host.wr(rows[i].a, rows[i].d);
         rchk(rows[i].a, rows[i].e);
      end
      $display("done registers");
      rst();
      check("play_cfg", play_cfg, {2'b00, cpr_pkg::DLY_RST});
      rchk(cpr_pkg::ADDR_CAL_CFG, 16'h0007);
      rchk(cpr_pkg::ADDR_DLY, 16'h000E);
      $display("done reset");
      i_host.wr(cpr_pkg::ADDR_DLY, 16'h0020);
      i_host.wr(cpr_pkg::ADDR_RPT_SEL, 16'h0001);
      i_host.wr(cpr_pkg::ADDR_PLAY_CMD, 16'h000D);
      cyc(1);
      check("play_cfg", play_cfg, 18'h0000E);
      check("sram_en", sram_access_en, 1'b1);
      rchk(cpr_pkg::ADDR_DLY, 16'h000E);
      i_host.wr(cpr_pkg::ADDR_UPDATE, 16'h0001);
      rchk(cpr_pkg::ADDR_UPDATE, 16'h0000);
      check("play_cfg", play_cfg, 18'h30020);
      rchk(cpr_pkg::ADDR_DLY, 16'h0020);
      $display("done update");
      fire(n);
      check("delay", 18'(n), 18'h00023);
      rchk(cpr_pkg::ADDR_PLAY_CMD, 16'h000F);
      pend(1);
      check("playing", playing, 1'b1);
      pend(1);
      cyc(2);
      check("playing", playing, 1'b0);
      i_host.wr(cpr_pkg::ADDR_RPT_SEL, 16'h0000);
      i_host.wr(cpr_pkg::ADDR_UPDATE, 16'h0001);
      fire(n);
      pend(3);
      check("playing", playing, 1'b1);
      i_host.wr(cpr_pkg::ADDR_PLAY_CMD, 16'h000C);
      i_host.wr(cpr_pkg::ADDR_UPDATE, 16'h0001);
      fall();
      cyc(3);
      check("playing", playing, 1'b0);
      $display("done playback");
      i_host.wr(cpr_pkg::ADDR_CAL_CFG, 16'h0073);
      i_host.wr(cpr_pkg::ADDR_CMP_OFS, 16'h0001);
      n = 0;
      repeat (100) begin
         @(posedge clock);
         n += int'(cal_tick);
      end
      check("ticks", 18'(n), 18'h00000);
      check("busy", cal_busy, 1'b1);
      check("gain_en", gain_cal_en, 1'b1);
      check("range", rng, 2'h3);
      i_host.wr(cpr_pkg::ADDR_CAL_CFG, 16'h004B);
      n = 0;
      while (cal_busy === 1'b1 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      check("busy", cal_busy, 1'b0);
      rchk(cpr_pkg::ADDR_CMP_OFS, 16'h5A03);
      rchk(cpr_pkg::ADDR_CAL_CFG, 16'h56CB);
      i_host.cal_reset(16'h004B);
      rchk(cpr_pkg::ADDR_CMP_OFS, 16'h0001);
      rchk(cpr_pkg::ADDR_CAL_CFG, 16'h004B);
      $display("done calibration");
      complete_run();
   end
endmodule // cpr_regs_test
